//--- rtl/rx_acq_bank.sv
// Purpose: receive acquisition configuration and status register bank
// Assumes: plain strobe port; read data one cycle after the read strobe
// Notes:   status inputs come from receive logic on sys_clk
module rx_acq_bank
    import rx_acq_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    // register port
    input  wire logic [ADDR_W-1:0]       reg_addr,
    input  wire logic [DATA_W-1:0]       reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [DATA_W-1:0]       reg_rdata,
    // receive status
    input  wire logic [7:0]              test_bus,
    input  wire logic [7:0]              carrier_quality,
    input  wire logic [7:0]              rx_signal_field,
    input  wire logic [7:0]              rx_service_field,
    input  wire logic [15:0]             rx_length_field,
    input  wire logic [7:0]              rx_header_crc_low,
    input  wire logic [7:0]              noise_floor_first_antenna,
    input  wire logic [7:0]              noise_floor_second_antenna,
    input  wire logic [7:0]              dc_offset_i,
    input  wire logic [7:0]              dc_offset_q,
    input  wire logic [7:0]              multipath_metric,
    input  wire logic [7:0]              multipath_count,
    // decision inputs
    input  wire logic [7:0]              rssi,
    input  wire logic [7:0]              noise_floor,
    input  wire logic                    tone_detected,
    input  wire logic                    delay_spread_low,
    input  wire logic [7:0]              tone_rssi_limit,
    input  wire logic                    energy_detect,
    input  wire logic                    primary_quality_pass,
    input  wire logic                    seed_select,
    input  wire logic [5:0]              adapted_quality_thr,
    // configuration to the receive path
    output logic                         dc_offset_enable,
    output logic                         use_default_weights,
    output logic [COEFF_W-1:0]           preamble_lead,
    output logic [COEFF_W-1:0]           preamble_lag,
    output logic [COEFF_W-1:0]           header_lead,
    output logic [COEFF_W-1:0]           header_lag,
    output logic [7:0]                   false_alarm_target,
    output logic [23:0]                  false_alarm_rate,
    output logic                         all_short_preamble,
    output logic                         diversity_use_rssi,
    output logic [QUAL_THR_W-1:0]        verify_quality_thr,
    output logic [QUAL_THR_W-1:0]        primary_quality_thr,
    output logic [QUAL_THR_W-1:0]        initial_quality_thr,
    output logic                         far_adjust_enable,
    output logic                         acquisition_gate,
    output logic [SEED_W-1:0]            scrambler_seed
);
    // =========================================================
    // writable registers
    logic [7:0]          rw_q [RW_COUNT];
    logic [RW_COUNT-1:0] wr_sel;

    // =========================================================
    // elaboration checks
    // the decode chains name every offset, so the map cannot stretch
    if (RW_COUNT != 12) begin : g_bad_rw_count
        $error("writable register count must be twelve");
    end
    if (DATA_W != 8 || ADDR_W != 8) begin : g_bad_bus
        $error("register port must be eight bits wide");
    end
    if (SEED_W >= DATA_W) begin : g_bad_seed
        $error("seed field must leave room for the view bit");
    end
    if (BIT_VIEW_SEL != DATA_W - 1) begin : g_bad_view_bit
        $error("view select must be the top bit of its register");
    end
    if (QUAL_THR_W > BIT_ED_GATE) begin : g_bad_thr
        $error("threshold field overlaps the control bits");
    end
    if (SNR_TWO_W > DATA_W || DC_THR_W > DATA_W) begin : g_bad_field
        $error("threshold field wider than its register");
    end

    // =========================================================
    // write decode; read-only, odd and unmapped offsets select nothing
    always_comb begin
        wr_sel = '0;
        if (!reg_wr) begin
            wr_sel = '0;
        end else if (reg_addr == OFF_SNR_ONE) begin
            wr_sel[0] = 1'b1;
        end else if (reg_addr == OFF_SNR_TWO) begin
            wr_sel[1] = 1'b1;
        end else if (reg_addr == OFF_DC_THR) begin
            wr_sel[2] = 1'b1;
        end else if (reg_addr == OFF_PRE_LEAD) begin
            wr_sel[3] = 1'b1;
        end else if (reg_addr == OFF_PRE_LAG) begin
            wr_sel[4] = 1'b1;
        end else if (reg_addr == OFF_HDR_LEAD) begin
            wr_sel[5] = 1'b1;
        end else if (reg_addr == OFF_HDR_LAG) begin
            wr_sel[6] = 1'b1;
        end else if (reg_addr == OFF_FA_TARGET) begin
            wr_sel[7] = 1'b1;
        end else if (reg_addr == OFF_ACQ_TIME) begin
            wr_sel[8] = 1'b1;
        end else if (reg_addr == OFF_ACQ_THR) begin
            wr_sel[9] = 1'b1;
        end else if (reg_addr == OFF_LONG_SEED) begin
            wr_sel[10] = 1'b1;
        end else if (reg_addr == OFF_SHORT_SEED) begin
            wr_sel[11] = 1'b1;
        end
    end

    for (genvar i = 0; i < RW_COUNT; i++) begin : g_rw
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                rw_q[i] <= RW_RESET;
            end else if (wr_sel[i]) begin
                rw_q[i] <= reg_wdata;
            end
        end
    end

    // named views of the writable bytes
    logic [7:0] snr_threshold_one_q;
    logic [7:0] snr_threshold_two_q;
    logic [7:0] dc_offset_threshold_q;
    logic [7:0] acquisition_timeline_q;
    logic [7:0] acquisition_thresholds_q;
    logic [7:0] long_preamble_seed_q;
    logic [7:0] short_seed_and_view_select_q;
    assign snr_threshold_one_q          = rw_q[0];
    assign snr_threshold_two_q          = rw_q[1];
    assign dc_offset_threshold_q        = rw_q[2];
    assign acquisition_timeline_q       = rw_q[8];
    assign acquisition_thresholds_q     = rw_q[9];
    assign long_preamble_seed_q         = rw_q[10];
    assign short_seed_and_view_select_q = rw_q[11];

    // =========================================================
    // configuration outputs
    // preamble and header coefficients, false alarm, timeline and threshold fields
    assign preamble_lead = rw_q[3][COEFF_W-1:0];
    assign preamble_lag  = rw_q[4][COEFF_W-1:0];
    assign header_lead   = rw_q[5][COEFF_W-1:0];
    assign header_lag    = rw_q[6][COEFF_W-1:0];
    assign false_alarm_target = rw_q[7];
    assign false_alarm_rate   = {11'h000, rw_q[7], 5'h00};
    assign all_short_preamble = acquisition_timeline_q[BIT_LONG_DIS];
    assign diversity_use_rssi = acquisition_timeline_q[BIT_DIV_RSSI];
    assign verify_quality_thr = acquisition_timeline_q[QUAL_THR_W-1:0];
    assign initial_quality_thr = acquisition_thresholds_q[QUAL_THR_W-1:0];
    assign far_adjust_enable = !acquisition_thresholds_q[BIT_FAR_DIS];
    // outputs mixing live inputs are registered: one cycle late, glitch free
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            primary_quality_thr <= QUAL_THR_W'(RW_RESET);
        end else if (far_adjust_enable) begin
            primary_quality_thr <= adapted_quality_thr;
        end else begin
            primary_quality_thr <= initial_quality_thr;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acquisition_gate <= 1'b0;
        end else if (acquisition_thresholds_q[BIT_ED_GATE]) begin
            acquisition_gate <= energy_detect && primary_quality_pass;
        end else begin
            acquisition_gate <= primary_quality_pass;
        end
    end
    // seed choice
    // select comes from logic on sys_clk, so it needs no synchroniser
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            scrambler_seed <= SEED_W'(RW_RESET);
        end else if (seed_select) begin
            scrambler_seed <= short_seed_and_view_select_q[SEED_W-1:0];
        end else begin
            scrambler_seed <= long_preamble_seed_q[SEED_W-1:0];
        end
    end

    // =========================================================
    // strength comparisons; nine bits avoid wrap on the sums
    logic [8:0] dc_limit;
    logic [8:0] snr_one_limit;
    logic [8:0] snr_two_limit;
    logic [8:0] tone_limit;
    assign dc_limit = {1'b0, noise_floor}
        + 9'(dc_offset_threshold_q[DC_THR_W-1:0]);
    assign snr_one_limit = {1'b0, noise_floor}
        + 9'(snr_threshold_one_q[SNR_ONE_W-1:0]);
    assign snr_two_limit = {1'b0, noise_floor}
        + 9'(snr_threshold_two_q[SNR_TWO_W-1:0]);
    assign tone_limit = {1'b0, noise_floor} + {1'b0, tone_rssi_limit};

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dc_offset_enable <= 1'b0;
        end else begin
            dc_offset_enable <= {1'b0, rssi} > dc_limit;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            use_default_weights <= 1'b1;
        end else begin
            use_default_weights <=
                (tone_detected && {1'b0, rssi} < tone_limit)
                || (!tone_detected && {1'b0, rssi} < snr_one_limit)
                || (!tone_detected && delay_spread_low
                    && {1'b0, rssi} < snr_two_limit);
        end
    end

    // =========================================================
    // read-only views
    rx_view_if views ();
    assign views.diag_sel = short_seed_and_view_select_q[BIT_VIEW_SEL];
    assign views.hdr[0]  = carrier_quality;
    assign views.diag[0] = noise_floor_first_antenna;
    assign views.hdr[1]  = rx_signal_field;
    assign views.diag[1] = noise_floor_second_antenna;
    assign views.hdr[2]  = rx_service_field;
    assign views.diag[2] = dc_offset_i;
    assign views.hdr[3]  = rx_length_field[7:0];
    assign views.diag[3] = dc_offset_q;
    assign views.hdr[4]  = rx_length_field[15:8];
    assign views.diag[4] = multipath_metric;
    assign views.hdr[5]  = rx_header_crc_low;
    assign views.diag[5] = multipath_count;

    rx_view_mux u_view_mux (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .views   (views)
    );

    // =========================================================
    // read port; views are one cycle old, ample for slow status
    logic [7:0] rdata_d;
    always_comb begin
        rdata_d = READ_ZERO;
        // writable bytes first, then the read-only block
        if (reg_addr == OFF_SNR_ONE) begin
            rdata_d = rw_q[0];
        end else if (reg_addr == OFF_SNR_TWO) begin
            rdata_d = rw_q[1];
        end else if (reg_addr == OFF_DC_THR) begin
            rdata_d = rw_q[2];
        end else if (reg_addr == OFF_PRE_LEAD) begin
            rdata_d = rw_q[3];
        end else if (reg_addr == OFF_PRE_LAG) begin
            rdata_d = rw_q[4];
        end else if (reg_addr == OFF_HDR_LEAD) begin
            rdata_d = rw_q[5];
        end else if (reg_addr == OFF_HDR_LAG) begin
            rdata_d = rw_q[6];
        end else if (reg_addr == OFF_FA_TARGET) begin
            rdata_d = rw_q[7];
        end else if (reg_addr == OFF_ACQ_TIME) begin
            rdata_d = rw_q[8];
        end else if (reg_addr == OFF_ACQ_THR) begin
            rdata_d = rw_q[9];
        end else if (reg_addr == OFF_LONG_SEED) begin
            rdata_d = rw_q[10];
        end else if (reg_addr == OFF_SHORT_SEED) begin
            rdata_d = rw_q[11];
        end else if (reg_addr == OFF_TEST_BUS) begin
            rdata_d = test_bus;
        end else if (reg_addr == OFF_QUAL_NA) begin
            rdata_d = views.shown[0];
        end else if (reg_addr == OFF_SIG_NB) begin
            rdata_d = views.shown[1];
        end else if (reg_addr == OFF_SVC_IOFF) begin
            rdata_d = views.shown[2];
        end else if (reg_addr == OFF_LENL_QOFF) begin
            rdata_d = views.shown[3];
        end else if (reg_addr == OFF_LENH_MP) begin
            rdata_d = views.shown[4];
        end else if (reg_addr == OFF_CRCL_MPC) begin
            rdata_d = views.shown[5];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= READ_ZERO;
        end
    end
endmodule

//--- shared/rx_acq_pkg.sv
// Purpose: constants shared by the receive acquisition register bank
// Assumes: byte-wide registers at printed byte offsets
// Notes:   offsets are even; the address port carries them directly
package rx_acq_pkg;
    // =========================================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // =========================================================
    // register offsets
    localparam logic [7:0] OFF_SNR_ONE    = 8'h4C;
    localparam logic [7:0] OFF_SNR_TWO    = 8'h4E;
    localparam logic [7:0] OFF_DC_THR     = 8'h50;
    localparam logic [7:0] OFF_PRE_LEAD   = 8'h52;
    localparam logic [7:0] OFF_PRE_LAG    = 8'h54;
    localparam logic [7:0] OFF_HDR_LEAD   = 8'h56;
    localparam logic [7:0] OFF_HDR_LAG    = 8'h58;
    localparam logic [7:0] OFF_FA_TARGET  = 8'h5A;
    localparam logic [7:0] OFF_ACQ_TIME   = 8'h5C;
    localparam logic [7:0] OFF_ACQ_THR    = 8'h5E;
    localparam logic [7:0] OFF_LONG_SEED  = 8'h60;
    localparam logic [7:0] OFF_SHORT_SEED = 8'h62;
    localparam logic [7:0] OFF_TEST_BUS   = 8'h64;
    localparam logic [7:0] OFF_QUAL_NA    = 8'h66;
    localparam logic [7:0] OFF_SIG_NB     = 8'h68;
    localparam logic [7:0] OFF_SVC_IOFF   = 8'h6A;
    localparam logic [7:0] OFF_LENL_QOFF  = 8'h6C;
    localparam logic [7:0] OFF_LENH_MP    = 8'h6E;
    localparam logic [7:0] OFF_CRCL_MPC   = 8'h70;

    // first offset and count of the writable block
    localparam logic [7:0] OFF_RW_BASE    = 8'h4C;
    localparam int         RW_COUNT       = 12;

    // =========================================================
    // field positions
    localparam int SNR_ONE_W    = 4;
    localparam int SNR_TWO_W    = 5;
    localparam int DC_THR_W     = 6;
    localparam int COEFF_W      = 6;
    localparam int QUAL_THR_W   = 6;
    localparam int SEED_W       = 7;
    localparam int BIT_LONG_DIS = 7;
    localparam int BIT_DIV_RSSI = 6;
    localparam int BIT_FAR_DIS  = 7;
    localparam int BIT_ED_GATE  = 6;
    localparam int BIT_VIEW_SEL = 7;

    // reset value of every writable register
    localparam logic [7:0] RW_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // false alarm rate step: rate = n * 32 / 2^16
    localparam int FAR_SHIFT = 5;
endpackage

//--- shared/rx_view_if.sv
// Purpose: carries the two read-only views into the view mux
// Assumes: all fields on sys_clk
// Notes:   header view (b) and diagnostic view (a)
interface rx_view_if;
    logic [7:0] hdr [6];
    logic [7:0] diag [6];
    logic       diag_sel;
    logic [7:0] shown [6];
    modport mux  (input hdr, input diag, input diag_sel, output shown);
    modport bank (output hdr, output diag, output diag_sel, input shown);
endinterface

//--- rtl/rx_view_mux.sv
// Purpose: registered selection between header and diagnostic views
// Assumes: one clock, asynchronous active-low reset
// Notes:   one cycle of latency on every view register
module rx_view_mux
    import rx_acq_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset_n,
    rx_view_if.mux    views
);
    // =========================================================
    // per-register view selection
    for (genvar i = 0; i < 6; i++) begin : g_view
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                views.shown[i] <= READ_ZERO;
            end else if (views.diag_sel) begin
                views.shown[i] <= views.diag[i];
            end else begin
                views.shown[i] <= views.hdr[i];
            end
        end
    end
endmodule

//--- verification/rx_acq_bank_props.sv
// Purpose: port checks for the acquisition register bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   writable bytes are shadowed from observed writes
module rx_acq_bank_props
    import rx_acq_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [7:0]  test_bus,
    input wire logic [7:0]  rssi,
    input wire logic [7:0]  noise_floor,
    input wire logic        energy_detect,
    input wire logic        primary_quality_pass,
    input wire logic        seed_select,
    input wire logic [5:0]  adapted_quality_thr,
    input wire logic        dc_offset_enable,
    input wire logic [5:0]  preamble_lead,
    input wire logic [5:0]  header_lag,
    input wire logic [7:0]  false_alarm_target,
    input wire logic [23:0] false_alarm_rate,
    input wire logic        all_short_preamble,
    input wire logic [5:0]  primary_quality_thr,
    input wire logic        far_adjust_enable,
    input wire logic        acquisition_gate,
    input wire logic [6:0]  scrambler_seed
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // shadow state
    logic [7:0] sh_q [RW_COUNT];
    logic [7:0] exp_rd_q;
    logic       live_q;
    logic       dc_exp_q;
    logic       gate_exp_q;
    logic [5:0] thr_exp_q;
    logic [6:0] seed_exp_q;
    logic       rw_hit;
    logic [7:0] rw_idx;
    assign rw_idx = (reg_addr - OFF_RW_BASE) >> 1;
    assign rw_hit = !reg_addr[0] && reg_addr >= OFF_RW_BASE
                    && reg_addr <= OFF_SHORT_SEED;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < RW_COUNT; i++)
                sh_q[i] <= RW_RESET;
        end else if (reg_wr && rw_hit) begin
            sh_q[rw_idx[3:0]] <= reg_wdata;
        end
    end
    // live_q hides the first edge, where outputs still hold reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            live_q   <= 1'b0;
            exp_rd_q <= 8'h00;
            dc_exp_q <= 1'b0;
            gate_exp_q <= 1'b0;
            thr_exp_q  <= 6'h00;
            seed_exp_q <= 7'h00;
        end else begin
            live_q   <= 1'b1;
            exp_rd_q <= rw_hit ? sh_q[rw_idx[3:0]] : test_bus;
            dc_exp_q <= {1'b0, rssi} > {1'b0, noise_floor} + sh_q[2][5:0];
            gate_exp_q <= primary_quality_pass
                          && (energy_detect || !sh_q[9][6]);
            thr_exp_q  <= sh_q[9][7] ? sh_q[9][5:0] : adapted_quality_thr;
            seed_exp_q <= seed_select ? sh_q[11][6:0] : sh_q[10][6:0];
        end
    end
    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rw_read;
        reg_rd && rw_hit;
    endsequence
    a_read_back: assert property (s_rw_read |=> reg_rdata == exp_rd_q)
        else $error("read data differs from last write");
    a_test_bus_read: assert property (
        reg_rd && reg_addr == OFF_TEST_BUS |=> reg_rdata == exp_rd_q)
        else $error("test bus read wrong");
    a_rdata_idle: assert property (
        live_q && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_dc_enable: assert property (live_q |-> dc_offset_enable == dc_exp_q)
        else $error("dc offset enable wrong");
    a_coeff_map: assert property (preamble_lead == sh_q[3][5:0]
        && header_lag == sh_q[6][5:0]) else $error("coefficient wrong");
    a_rate_scale: assert property (false_alarm_target == sh_q[7]
        && false_alarm_rate == {11'h000, sh_q[7], 5'h00})
        else $error("false alarm rate wrong");
    a_timeline_bit: assert property (
        all_short_preamble == sh_q[8][7]) else $error("timeline bit wrong");
    a_gate_mode: assert property (
        live_q |-> acquisition_gate == gate_exp_q)
        else $error("acquisition gate wrong");
    a_quality_freeze: assert property (
        live_q |-> far_adjust_enable == !sh_q[9][7]
        && primary_quality_thr == thr_exp_q)
        else $error("quality threshold wrong");
    a_seed_choice: assert property (
        live_q |-> scrambler_seed == seed_exp_q) else $error("seed wrong");
endmodule

bind rx_acq_bank rx_acq_bank_props u_props (.*);

//--- verification/rx_acq_bank_tb.sv
// Purpose: self-checking bench for the acquisition register bank
// Assumes: read data valid only in the cycle after the read strobe
// Notes:   status inputs are held still while views are read
module rx_acq_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rx_acq_pkg::*;
    logic        sys_clk, reset_n, reg_wr, reg_rd, tone_detected;
    logic        delay_spread_low, energy_detect, primary_quality_pass;
    logic        seed_select, dc_offset_enable, use_default_weights;
    logic        all_short_preamble, diversity_use_rssi, far_adjust_enable;
    logic        acquisition_gate;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, test_bus, carrier_quality;
    logic [7:0]  rx_signal_field, rx_service_field, rx_header_crc_low;
    logic [7:0]  noise_floor_first_antenna, noise_floor_second_antenna;
    logic [7:0]  dc_offset_i, dc_offset_q, multipath_metric, multipath_count;
    logic [7:0]  rssi, noise_floor, tone_rssi_limit, false_alarm_target;
    logic [15:0] rx_length_field;
    logic [5:0]  adapted_quality_thr, preamble_lead, preamble_lag;
    logic [5:0]  header_lead, header_lag, verify_quality_thr;
    logic [5:0]  primary_quality_thr, initial_quality_thr;
    logic [23:0] false_alarm_rate;
    logic [6:0]  scrambler_seed;
    logic [7:0]  exp_q [RW_COUNT];
    int          num_errors = 0;
    int          num_checks = 0;

    rx_acq_bank DUT (.*);

    // ==========================================================
    // helpers
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic wr_m(input int i, input logic [7:0] d);
        exp_q[i] = d;
        wr(OFF_RW_BASE + 8'(2 * i), d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    function automatic logic [7:0] view_exp(input int j, input logic diag);
        logic [7:0] a [6];
        logic [7:0] b [6];
        a = '{noise_floor_first_antenna, noise_floor_second_antenna,
              dc_offset_i, dc_offset_q, multipath_metric, multipath_count};
        b = '{carrier_quality, rx_signal_field, rx_service_field,
              rx_length_field[7:0], rx_length_field[15:8], rx_header_crc_low};
        return diag ? a[j] : b[j];
    endfunction
    function automatic logic dw_exp();
        logic [8:0] nf;
        nf = {1'b0, noise_floor};
        return (tone_detected && rssi < nf + tone_rssi_limit)
            || (!tone_detected && rssi < nf + exp_q[0][3:0])
            || (!tone_detected && delay_spread_low
                && rssi < nf + exp_q[1][4:0]);
    endfunction
    function automatic logic [5:0] thr_exp();
        return exp_q[9][7] ? exp_q[9][5:0] : adapted_quality_thr;
    endfunction
    function automatic logic gate_exp();
        return primary_quality_pass && (energy_detect || !exp_q[9][6]);
    endfunction
    function automatic logic [6:0] seed_exp();
        return seed_select ? exp_q[11][6:0] : exp_q[10][6:0];
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog and sequence
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {tone_detected, delay_spread_low, energy_detect} = '0;
        {primary_quality_pass, seed_select, adapted_quality_thr} = '0;
        {test_bus, carrier_quality, rx_signal_field, rx_service_field} = '0;
        {rx_length_field, rx_header_crc_low, multipath_count} = '0;
        {noise_floor_first_antenna, noise_floor_second_antenna} = '0;
        {dc_offset_i, dc_offset_q, multipath_metric} = '0;
        {rssi, noise_floor, tone_rssi_limit} = '0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        void'($urandom(32'h0652));
        for (int i = 0; i < RW_COUNT; i++)
            rd_chk(OFF_RW_BASE + 8'(2 * i), RW_RESET);
        // unused upper bits must be stored too, so the first is all ones
        for (int i = 0; i < RW_COUNT; i++)
            wr_m(i, (i == 0) ? 8'hFF : 8'($urandom));
        for (int a = 8'h64; a <= 8'h72; a += 2)
            wr(8'(a), 8'hA5);
        wr(8'h4D, 8'h5A);
        for (int i = 0; i < RW_COUNT; i++)
            rd_chk(OFF_RW_BASE + 8'(2 * i), exp_q[i]);
        check(preamble_lag, exp_q[4][5:0]);
        check(header_lead, exp_q[5][5:0]);
        // second pass flips every bit of the timeline register
        for (int p = 0; p < 2; p++) begin
            if (p == 1)
                wr_m(8, ~exp_q[8]);
            #1 check(all_short_preamble, exp_q[8][7]);
            check(diversity_use_rssi, exp_q[8][6]);
            check(verify_quality_thr, exp_q[8][5:0]);
        end
        check(initial_quality_thr, exp_q[9][5:0]);
        rd_chk(8'h72, READ_ZERO);
        rd_chk(8'h4A, READ_ZERO);
        wr_m(7, 8'h10);
        #1 check(false_alarm_rate, 24'h000200);
        for (int v = 0; v < 2; v++) begin
            @(posedge sys_clk);
            {test_bus, carrier_quality} <= 16'($urandom);
            {rx_signal_field, rx_service_field} <= 16'($urandom);
            {rx_length_field, rx_header_crc_low} <= 24'($urandom);
            multipath_count <= 8'($urandom);
            {noise_floor_first_antenna, noise_floor_second_antenna,
             dc_offset_i, dc_offset_q} <= $urandom;
            multipath_metric <= 8'(v * 8'hFF);
            wr_m(11, {v[0], 7'h2B});
            repeat (2) @(posedge sys_clk);
            rd_chk(OFF_TEST_BUS, test_bus);
            for (int j = 0; j < 6; j++) begin
                rd_chk(OFF_QUAL_NA + 8'(2 * j), view_exp(j, v[0]));
            end
        end
        wr_m(2, 8'h05);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            noise_floor <= 8'h20;
            rssi        <= 8'h25 + 8'(k);
            repeat (2) @(posedge sys_clk);
            #1 check(dc_offset_enable, 24'(k));
        end
        for (int n = 0; n < 24; n++) begin
            wr_m(0, 8'($urandom));
            wr_m(1, 8'($urandom));
            wr_m(9, 8'($urandom));
            @(posedge sys_clk);
            {tone_detected, delay_spread_low, energy_detect} <= 3'($urandom);
            {primary_quality_pass, seed_select} <= 2'($urandom);
            adapted_quality_thr <= 6'($urandom);
            rssi            <= 8'($urandom);
            noise_floor     <= 8'($urandom) & 8'h7F;
            tone_rssi_limit <= 8'($urandom) & 8'h3F;
            repeat (2) @(posedge sys_clk);
            #1 check(use_default_weights, dw_exp());
            check(scrambler_seed, seed_exp());
            check(primary_quality_thr, thr_exp());
            check(acquisition_gate, gate_exp());
            check(initial_quality_thr, exp_q[9][5:0]);
        end
        report_and_stop();
    end
endmodule
